// >>> pkg/abu_pkg.sv
// Package for the address breakpoint unit: APB map, field positions, vectors.
// Assumes a 32-bit APB with word-aligned registers.
package abu_pkg;
  localparam logic [7:0]  ADDR_CTRL_STATUS  = 8'h00;
  localparam logic [7:0]  ADDR_MATCH_HIGH   = 8'h04;
  localparam logic [7:0]  ADDR_MATCH_LOW    = 8'h08;
  localparam logic [7:0]  ADDR_WAKE_STATUS  = 8'h0c;
  localparam logic [7:0]  ADDR_FLAG_CONTROL = 8'h10;
  localparam logic [7:0]  ADDR_IRQ_STATUS   = 8'h14;
  localparam logic [7:0]  ADDR_IRQ_MASK     = 8'h18;
  localparam int          BIT_ENABLE        = 7;
  localparam int          BIT_ACTIVE        = 6;
  localparam int          BIT_WAIT_EXIT     = 1;
  localparam int          BIT_STOP_EXIT     = 0;
  localparam int          BIT_PERMIT        = 7;
  localparam int          EVT_MATCH         = 0;
  localparam int          EVT_SOFT          = 1;
  localparam int          EVT_WAKE          = 2;
  localparam int          EVT_END           = 3;
  localparam int          EVT_W             = 4;
  localparam logic [15:0] VECTOR_NORMAL     = 16'hfffc;
  localparam logic [15:0] VECTOR_MONITOR    = 16'hfefc;
  localparam logic [7:0]  SOFT_INT_OPCODE   = 8'h83;
  localparam logic [7:0]  RESET_BYTE        = 8'h00;
  localparam logic [31:0] BAD_ADDR_DATA     = 32'h0000_0000;
endpackage : abu_pkg

// >>> rtl/abu_break_unit.sv
// Address breakpoint unit: match, break request, wake flags, APB registers.
// Assumes the CPU flags instruction end, wait, stop and interrupt return.
//
// What this block does
// - Compare program counter with the break address; equality is a break.
// - A detected match raises the breakpoint request to the CPU.
// - Accepted request makes the CPU load the soft interrupt after current instruction.
// - Break vector is FFFC/FFFD normally, FEFC/FEFD in monitor mode.
// - Match on an instruction's last cycle is flagged in pending_at_end; the break still waits for the CPU ack.
// - Software writing one to the active flag raises a break like a match.
// - Interrupt return inside the break routine ends the break state.
// - Timer counters are halted while a break is in progress.
// - Watchdog disabled in break only with test high voltage on reset pin.
// - Comparison and break generation keep working in wait mode when enabled.
// - The wait-exit flag is cleared by writing zero to it.
// - A break leaves stop mode and sets the break-exit status flag.
// - In break, flag_clear_allow is high only when the flag-clear permit bit is set; the unit's own flags clear regardless.
// - Match breaks need the enable bit 7; writing zero or reset clears it.
// - Hardware sets the active flag on match; the routine writes zero to clear it.
// - Hardware sets the wait-exit flag when a break ends wait mode.
// - Reset clears both break address bytes.
`timescale 1ns/100ps
module abu_break_unit
  import abu_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic        ce,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [15:0] cpu_pc,
  input  wire logic        cpu_pc_valid,
  input  wire logic        cpu_last_cycle,
  input  wire logic        cpu_break_ack,
  input  wire logic        cpu_rti_done,
  input  wire logic        cpu_in_wait,
  input  wire logic        cpu_in_stop,
  input  wire logic        monitor_mode,
  input  wire logic        test_high_voltage,
  output logic             break_request,
  output logic             break_inject,
  output logic [7:0]       inject_opcode,
  output logic [15:0]      break_vector,
  output logic             in_break,
  output logic             timer_halt,
  output logic             watchdog_disable,
  output logic             flag_clear_allow,
  output logic             wake_request,
  output logic             irq
);
  typedef enum logic [1:0] {ABU_IDLE, ABU_PENDING, ABU_BREAK} abu_state_type;

  abu_state_type   state;
  logic [7:0]      match_address_high;
  logic [7:0]      match_address_low;
  logic            break_enable_bit;
  logic            break_active_flag;
  logic            wait_exit_flag;
  logic            break_exit_status_flag;
  logic            flag_clear_permit;
  logic            pending_at_end;
  logic [EVT_W-1:0] evt_status;
  logic [EVT_W-1:0] evt_mask;
  logic            evt_irq;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ref_a);
    hit = (a == ref_a);
  endfunction : hit

  wire logic acc      = psel && penable;
  wire logic wr       = acc && pwrite && ce;
  wire logic rd       = acc && !pwrite && ce;
  wire logic wr_ctrl  = wr && (paddr == ADDR_CTRL_STATUS);
  wire logic wr_wake  = wr && (paddr == ADDR_WAKE_STATUS);
  wire logic soft_brk = wr_ctrl && pwdata[BIT_ACTIVE];
  // Both bytes must agree; one byte alone never breaks
  wire logic addr_eq  = hit(cpu_pc[15:8], match_address_high)
                      && hit(cpu_pc[7:0], match_address_low);
  wire logic match    = break_enable_bit && cpu_pc_valid && addr_eq
                      && (state == ABU_IDLE);
  wire logic trigger  = match || (soft_brk && state == ABU_IDLE);
  wire logic take     = (state == ABU_PENDING) && cpu_break_ack;
  wire logic leave    = (state == ABU_BREAK) && cpu_rti_done;

  // Request stays up until the CPU accepts at an instruction boundary
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state <= ABU_IDLE;
    end else if (ce) begin
      case (state)
        ABU_IDLE:    if (trigger) state <= ABU_PENDING;
        ABU_PENDING: if (cpu_break_ack) state <= ABU_BREAK;
        ABU_BREAK:   if (cpu_rti_done) state <= ABU_IDLE;
        default:     state <= ABU_IDLE;
      endcase
    end
  end

  // Last-cycle match is flagged in pending_at_end; no output carries it to the CPU
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pending_at_end <= 1'b0;
    end else if (ce) begin
      if (trigger) pending_at_end <= cpu_last_cycle;
      else if (take) pending_at_end <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      break_request <= 1'b0;
      break_inject  <= 1'b0;
      in_break      <= 1'b0;
      inject_opcode <= RESET_BYTE;
      break_vector  <= VECTOR_NORMAL;
    end else if (ce) begin
      break_request <= trigger || (state == ABU_PENDING && !cpu_break_ack);
      break_inject  <= take;
      inject_opcode <= SOFT_INT_OPCODE;
      break_vector  <= monitor_mode ? VECTOR_MONITOR : VECTOR_NORMAL;
      in_break      <= (state == ABU_BREAK && !cpu_rti_done) || take;
    end
  end

  wire logic brk_next = (state == ABU_BREAK && !cpu_rti_done) || take;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      timer_halt       <= 1'b0;
      watchdog_disable <= 1'b0;
      flag_clear_allow <= 1'b1;
    end else if (ce) begin
      timer_halt       <= brk_next;
      watchdog_disable <= brk_next && test_high_voltage;
      flag_clear_allow <= !brk_next || flag_clear_permit;
    end
  end

  // Wake pulses for one cycle when a break triggers in wait or stop
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wake_request <= 1'b0;
    end else if (ce) begin
      wake_request <= trigger && (cpu_in_wait || cpu_in_stop);
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      break_enable_bit  <= 1'b0;
      flag_clear_permit <= 1'b0;
    end else if (wr_ctrl) begin
      break_enable_bit <= pwdata[BIT_ENABLE];
    end else if (wr && paddr == ADDR_FLAG_CONTROL) begin
      flag_clear_permit <= pwdata[BIT_PERMIT];
    end
  end

  // Hardware set wins over a same-cycle write of zero
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      break_active_flag <= 1'b0;
    end else if (ce) begin
      if (match || soft_brk) break_active_flag <= 1'b1;
      else if (wr_ctrl) break_active_flag <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wait_exit_flag         <= 1'b0;
      break_exit_status_flag <= 1'b0;
    end else if (ce) begin
      if (trigger && cpu_in_wait) wait_exit_flag <= 1'b1;
      else if (wr_wake && !pwdata[BIT_WAIT_EXIT]) wait_exit_flag <= 1'b0;
      if (trigger && cpu_in_stop) break_exit_status_flag <= 1'b1;
      else if (wr_wake && !pwdata[BIT_STOP_EXIT]) break_exit_status_flag <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      match_address_high <= RESET_BYTE;
      match_address_low  <= RESET_BYTE;
    end else if (wr && paddr == ADDR_MATCH_HIGH) begin
      match_address_high <= pwdata[7:0];
    end else if (wr && paddr == ADDR_MATCH_LOW) begin
      match_address_low <= pwdata[7:0];
    end
  end

  abu_event_reg u_events (
    .clk_sys     (clk_sys),
    .rst         (rst),
    .ce          (ce),
    .event_pulse ({leave, (trigger && (cpu_in_wait || cpu_in_stop)), soft_brk, match}),
    .status_read (rd && paddr == ADDR_IRQ_STATUS),
    .mask_write  (wr && paddr == ADDR_IRQ_MASK),
    .mask_data   (pwdata[EVT_W-1:0]),
    .status      (evt_status),
    .mask        (evt_mask),
    .irq         (evt_irq)
  );
  assign irq = evt_irq;

  // Answer in the first cycle of the access phase; unmapped reads give zero
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= BAD_ADDR_DATA;
    end else if (ce) begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && (paddr > ADDR_IRQ_MASK || paddr[1:0] != 2'b00);
      case (paddr)
        ADDR_CTRL_STATUS:  prdata <= {24'h0, break_enable_bit, break_active_flag, 6'h0};
        ADDR_MATCH_HIGH:   prdata <= {24'h0, match_address_high};
        ADDR_MATCH_LOW:    prdata <= {24'h0, match_address_low};
        ADDR_WAKE_STATUS:  prdata <= {30'h0, wait_exit_flag, break_exit_status_flag};
        ADDR_FLAG_CONTROL: prdata <= {24'h0, flag_clear_permit, 7'h0};
        ADDR_IRQ_STATUS:   prdata <= {28'h0, evt_status};
        ADDR_IRQ_MASK:     prdata <= {28'h0, evt_mask};
        default:           prdata <= BAD_ADDR_DATA;
      endcase
    end
  end

  // Match and request
  a_match_request: assert property (@(posedge clk_sys) disable iff (rst)
    (ce && match) |=> break_request) else $error("match without request");
  a_full_match: assert property (@(posedge clk_sys) disable iff (rst)
    (ce && state == ABU_IDLE && break_enable_bit && cpu_pc_valid
     && cpu_pc == {match_address_high, match_address_low}) |=> break_request)
    else $error("full match missed");
  a_high_only: assert property (@(posedge clk_sys) disable iff (rst)
    (ce && state == ABU_IDLE && !soft_brk && cpu_pc[15:8] == match_address_high
     && cpu_pc[7:0] != match_address_low) |=> state == ABU_IDLE)
    else $error("high byte alone broke");
  a_low_only: assert property (@(posedge clk_sys) disable iff (rst)
    (ce && state == ABU_IDLE && !soft_brk && cpu_pc[7:0] == match_address_low
     && cpu_pc[15:8] != match_address_high) |=> state == ABU_IDLE)
    else $error("low byte alone broke");
  a_request_hold: assert property (@(posedge clk_sys) disable iff (rst)
    (ce && state == ABU_PENDING && !cpu_break_ack) |=> break_request)
    else $error("request dropped before ack");
  // A last-cycle match must be flagged at once in pending_at_end, which no output carries
  a_last_cycle: assert property (@(posedge clk_sys) disable iff (rst)
    (ce && trigger && cpu_last_cycle) |=> pending_at_end && break_request)
    else $error("last cycle match not flagged");
  a_wait_match: assert property (@(posedge clk_sys) disable iff (rst)
    (ce && match && cpu_in_wait) |=> break_request && wake_request)
    else $error("match lost in wait");
  a_enable_gate: assert property (@(posedge clk_sys) disable iff (rst)
    (ce && state == ABU_IDLE && !break_enable_bit && !soft_brk) |=> state == ABU_IDLE)
    else $error("break while disabled");
  a_soft_break: assert property (@(posedge clk_sys) disable iff (rst)
    (ce && soft_brk && state == ABU_IDLE) |=> break_active_flag && break_request)
    else $error("soft break lost");
  a_active_set: assert property (@(posedge clk_sys) disable iff (rst)
    (ce && match) |=> break_active_flag) else $error("active flag not set");
  a_active_clear: assert property (@(posedge clk_sys) disable iff (rst)
    (ce && wr_ctrl && !pwdata[BIT_ACTIVE] && !match) |=> !break_active_flag)
    else $error("active flag not cleared");
  // No disable here, the check looks at the cycle right after reset
  a_addr_reset: assert property (@(posedge clk_sys)
    rst |=> match_address_high == RESET_BYTE && match_address_low == RESET_BYTE)
    else $error("break address not cleared");

  // Break entry and exit
  a_inject_opcode: assert property (@(posedge clk_sys) disable iff (rst)
    (ce && take) |=> break_inject && inject_opcode == SOFT_INT_OPCODE)
    else $error("soft interrupt not injected");
  a_vector_sel: assert property (@(posedge clk_sys) disable iff (rst)
    (ce && $stable(monitor_mode) && monitor_mode) |=> break_vector == VECTOR_MONITOR)
    else $error("vector wrong");
  a_vector_normal: assert property (@(posedge clk_sys) disable iff (rst)
    (ce && !monitor_mode) |=> break_vector == VECTOR_NORMAL)
    else $error("normal vector wrong");
  a_rti_end: assert property (@(posedge clk_sys) disable iff (rst)
    (ce && leave) |=> !in_break ##1 !timer_halt) else $error("break not ended");
  a_rti_idle: assert property (@(posedge clk_sys) disable iff (rst)
    (ce && leave) |=> state == ABU_IDLE) else $error("state kept after return");
  a_timer_halt: assert property (@(posedge clk_sys) disable iff (rst)
    (ce && take) |=> timer_halt) else $error("timer not halted");
  a_timer_release: assert property (@(posedge clk_sys) disable iff (rst)
    (ce && !brk_next) |=> !timer_halt) else $error("timer halted outside break");
  a_watchdog_gate: assert property (@(posedge clk_sys) disable iff (rst)
    watchdog_disable |-> timer_halt) else $error("watchdog off outside break");
  a_watchdog_test: assert property (@(posedge clk_sys) disable iff (rst)
    (ce && brk_next) |=> watchdog_disable == $past(test_high_voltage))
    else $error("watchdog gate ignores test voltage");
  a_permit_gate: assert property (@(posedge clk_sys) disable iff (rst)
    (ce && brk_next) |=> flag_clear_allow == $past(flag_clear_permit))
    else $error("flag clear not gated in break");
  a_permit_free: assert property (@(posedge clk_sys) disable iff (rst)
    (ce && !brk_next) |=> flag_clear_allow) else $error("flag clear blocked outside break");

  // Wake flags
  a_wait_flag_set: assert property (@(posedge clk_sys) disable iff (rst)
    (ce && trigger && cpu_in_wait) |=> wait_exit_flag) else $error("wait flag");
  a_wait_clear: assert property (@(posedge clk_sys) disable iff (rst)
    (ce && wr_wake && !pwdata[BIT_WAIT_EXIT] && !(trigger && cpu_in_wait))
    |=> !wait_exit_flag) else $error("wait flag not cleared");
  a_stop_flag_set: assert property (@(posedge clk_sys) disable iff (rst)
    (ce && trigger && cpu_in_stop) |=> break_exit_status_flag && wake_request)
    else $error("stop exit");
  a_stop_clear: assert property (@(posedge clk_sys) disable iff (rst)
    (ce && wr_wake && !pwdata[BIT_STOP_EXIT] && !(trigger && cpu_in_stop))
    |=> !break_exit_status_flag) else $error("stop flag not cleared");

  c_match_break: cover property (@(posedge clk_sys) disable iff (rst) match ##[1:20] take);
  c_soft_break:  cover property (@(posedge clk_sys) disable iff (rst) soft_brk);
  c_wait_wake:   cover property (@(posedge clk_sys) disable iff (rst) trigger && cpu_in_wait);
  c_stop_wake:   cover property (@(posedge clk_sys) disable iff (rst) trigger && cpu_in_stop);
  c_rti:         cover property (@(posedge clk_sys) disable iff (rst) leave);
endmodule : abu_break_unit

// >>> rtl/abu_event_reg.sv
// Sticky event status, read-to-clear, with a mask and a level interrupt.
// Assumes events are one-cycle pulses on clk_sys.
`timescale 1ns/100ps
module abu_event_reg
  import abu_pkg::*;
(
  input  wire logic             clk_sys,
  input  wire logic             rst,
  input  wire logic             ce,
  input  wire logic [EVT_W-1:0] event_pulse,
  input  wire logic             status_read,
  input  wire logic             mask_write,
  input  wire logic [EVT_W-1:0] mask_data,
  output logic      [EVT_W-1:0] status,
  output logic      [EVT_W-1:0] mask,
  output logic                  irq
);
  // A new event wins over the read that clears
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      status <= '0;
    end else if (ce) begin
      status <= (status_read ? '0 : status) | event_pulse;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      mask <= '0;
    end else if (ce && mask_write) begin
      mask <= mask_data;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      irq <= 1'b0;
    end else if (ce) begin
      irq <= |(((status_read ? '0 : status) | event_pulse) & mask);
    end
  end
endmodule : abu_event_reg

// >>> tb/abu_cpu_model.sv
// CPU stand-in: sequential fetches, acks break requests, runs a short routine.
// Assumes the bench picks the start address, ack delay and wait-exit state.
`timescale 1ns/100ps
module abu_cpu_model (
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic        jump,
  input  wire logic [15:0] jump_addr,
  input  wire logic [2:0]  ack_dly,
  input  wire logic        wait_flag,
  input  wire logic        break_request,
  input  wire logic        break_inject,
  input  wire logic [15:0] break_vector,
  output logic      [15:0] cpu_pc,
  output logic             cpu_pc_valid,
  output logic             cpu_last_cycle,
  output logic             cpu_break_ack,
  output logic             cpu_rti_done
);
  logic [2:0]  wait_cnt;
  logic [3:0]  isr_cnt;
  logic [15:0] ret_pc;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cpu_pc         <= 16'h0000;
      cpu_pc_valid   <= 1'b0;
      cpu_last_cycle <= 1'b0;
      isr_cnt        <= 4'h0;
      ret_pc         <= 16'h0000;
    end else if (break_inject) begin
      // Return lands past the match so the same address cannot re-trigger
      ret_pc  <= cpu_pc + 16'h0004;
      cpu_pc  <= break_vector;
      isr_cnt <= 4'hf;
    end else if (jump) begin
      cpu_pc       <= jump_addr;
      cpu_pc_valid <= 1'b1;
    end else if (isr_cnt == 4'h1) begin
      cpu_pc  <= ret_pc - {15'h0000, wait_flag};
      isr_cnt <= 4'h0;
    end else begin
      cpu_last_cycle <= ~cpu_last_cycle;
      if (cpu_last_cycle) cpu_pc <= cpu_pc + 16'h0001;
      if (isr_cnt != 4'h0) isr_cnt <= isr_cnt - 4'h1;
    end
  end
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wait_cnt      <= 3'h0;
      cpu_break_ack <= 1'b0;
      cpu_rti_done  <= 1'b0;
    end else begin
      wait_cnt      <= break_request ? wait_cnt + 3'h1 : 3'h0;
      cpu_break_ack <= break_request && !cpu_break_ack && cpu_last_cycle
                       && (wait_cnt >= ack_dly);
      cpu_rti_done  <= (isr_cnt == 4'h1);
    end
  end
endmodule : abu_cpu_model

// >>> tb/tb_abu_break_unit.sv
// Bench for the break unit: APB tasks, CPU model, queued result checks.
// Assumes zero-wait APB slave and the CPU model beside it.
`timescale 1ns/100ps
module tb_abu_break_unit;
  import abu_pkg::*;
  logic        clk_sys, rst, ce, psel, penable, pwrite, pready, pslverr, jump, wflag;
  logic        monitor_mode, test_high_voltage, cpu_in_wait, cpu_in_stop;
  logic        pcv, last, ack, interrupt_return_opcode, breq, binj, in_break, thalt, wdd, fca, wreq, irq;
  logic [7:0]  paddr, opc, hi, lo;
  logic [2:0]  adly;
  logic [15:0] pc, jaddr, vec;
  logic [31:0] pwdata, prdata, seed;
  logic [32:0] q_rd[$];
  logic [27:0] q_brk[$];
  int          error_cnt = 0;
  int          tests_run = 0;
  abu_break_unit uut (.clk_sys(clk_sys), .rst(rst), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cpu_pc(pc), .cpu_pc_valid(pcv), .cpu_last_cycle(last),
    .cpu_break_ack(ack), .cpu_rti_done(interrupt_return_opcode), .cpu_in_wait(cpu_in_wait),
    .cpu_in_stop(cpu_in_stop), .monitor_mode(monitor_mode),
    .test_high_voltage(test_high_voltage), .break_request(breq), .break_inject(binj),
    .inject_opcode(opc), .break_vector(vec), .in_break(in_break), .timer_halt(thalt),
    .watchdog_disable(wdd), .flag_clear_allow(fca), .wake_request(wreq), .irq(irq));
  abu_cpu_model cpu (.clk_sys(clk_sys), .rst(rst), .jump(jump), .jump_addr(jaddr),
    .ack_dly(adly), .wait_flag(wflag), .break_request(breq), .break_inject(binj),
    .break_vector(vec), .cpu_pc(pc), .cpu_pc_valid(pcv), .cpu_last_cycle(last),
    .cpu_break_ack(ack), .cpu_rti_done(interrupt_return_opcode));
  task automatic conclude;
    $display("mismatches %0d comparisons %0d", error_cnt, tests_run);
    if (error_cnt == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : conclude
  task automatic cmp_rd(input logic [32:0] got, input logic [32:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp_rd
  task automatic cmp_brk(input logic [27:0] got, input logic [27:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp_brk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic e);
    int n;
    q_rd.push_back({e, w ? 32'h0 : d});
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      error_cnt++;
      conclude();
    end
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask : apb
  task automatic go(input logic [15:0] a, input int n);
    jaddr <= a;
    jump  <= 1'b1;
    @(posedge clk_sys);
    jump  <= 1'b0;
    repeat (n) @(posedge clk_sys);
  endtask : go
  task automatic wait_brk(input logic lvl);
    int n;
    n = 0;
    while (in_break !== lvl && n < 80) begin
      @(posedge clk_sys);
      n++;
    end
    if (n >= 80) begin
      error_cnt++;
      conclude();
    end
  endtask : wait_brk
  // Results are taken at the edge where they are sampled, ahead of the bench's own updates
  always @(posedge clk_sys) begin
    if (psel && penable && pready) cmp_rd({pslverr, pwrite ? 32'h0 : prdata}, q_rd.pop_front());
    if (binj) cmp_brk({vec, opc, thalt, wdd, fca, in_break}, q_brk.pop_front());
  end
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  initial begin
    rst = 1'b1; ce = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00;
    pwdata = 32'h0; jump = 1'b0; jaddr = 16'h0; adly = 3'h0; wflag = 1'b0;
    monitor_mode = 1'b0; test_high_voltage = 1'b0; cpu_in_wait = 1'b0; cpu_in_stop = 1'b0;
    seed = $urandom(32'hd3f5);
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    apb(1'b0, ADDR_CTRL_STATUS, 32'h0, 1'b0);
    apb(1'b0, ADDR_MATCH_HIGH, 32'h0, 1'b0);
    apb(1'b0, ADDR_MATCH_LOW, 32'h0, 1'b0);
    apb(1'b0, 8'h1c, 32'h0, 1'b1);
    hi = 8'h10 + 8'($urandom_range(0, 63));
    lo = 8'h10 + 8'($urandom_range(0, 200));
    apb(1'b1, ADDR_MATCH_HIGH, {24'h0, hi}, 1'b0);
    apb(1'b1, ADDR_MATCH_LOW, {24'h0, lo}, 1'b0);
    apb(1'b0, ADDR_MATCH_HIGH, {24'h0, hi}, 1'b0);
    go({hi, lo - 8'h08}, 30);
    apb(1'b1, ADDR_CTRL_STATUS, 32'h80, 1'b0);
    go({hi ^ 8'h01, lo - 8'h08}, 30);
    for (int i = 0; i < 4; i++) begin
      monitor_mode <= i[0];
      test_high_voltage <= i[1];
      adly <= 3'($urandom_range(0, 6));
      wflag <= (i == 2);
      apb(1'b1, ADDR_IRQ_MASK, (i == 3) ? 32'hf : 32'h0, 1'b0);
      apb(1'b1, ADDR_FLAG_CONTROL, {24'h0, i[0] ^ i[1], 7'h0}, 1'b0);
      cpu_in_wait <= (i == 2);
      cpu_in_stop <= (i == 3);
      q_brk.push_back({i[0] ? VECTOR_MONITOR : VECTOR_NORMAL, SOFT_INT_OPCODE,
                       1'b1, i[1], i[0] ^ i[1], 1'b1});
      if (i == 1) apb(1'b1, ADDR_CTRL_STATUS, 32'hc0, 1'b0);
      else go({hi, lo - 8'h08}, 0);
      wait_brk(1'b1);
      cpu_in_wait <= 1'b0;
      cpu_in_stop <= 1'b0;
      apb(1'b0, ADDR_CTRL_STATUS, 32'hc0, 1'b0);
      apb(1'b0, ADDR_WAKE_STATUS, {30'h0, i == 2, i == 3}, 1'b0);
      apb(1'b1, ADDR_CTRL_STATUS, 32'h80, 1'b0);
      wait_brk(1'b0);
      apb(1'b0, ADDR_CTRL_STATUS, 32'h80, 1'b0);
      apb(1'b1, ADDR_WAKE_STATUS, 32'h0, 1'b0);
      apb(1'b0, ADDR_WAKE_STATUS, 32'h0, 1'b0);
      repeat (2) @(posedge clk_sys);
      cmp_rd({32'h0, irq}, {32'h0, i == 3});
      apb(1'b0, ADDR_IRQ_STATUS, {28'h0, 1'b1, i >= 2, i == 1, i != 1}, 1'b0);
      repeat (2) @(posedge clk_sys);
      cmp_rd({32'h0, irq}, 33'h0);
    end
    conclude();
  end
endmodule : tb_abu_break_unit
